// ---- fpvi_pkg.sv ----
// Package for the fixed priority vectored interrupt block
package fpvi_pkg;
	// Source indices, highest priority first
	localparam int SRC_N           = 5;
	localparam int SRC_PIN_A       = 0;
	localparam int SRC_TIMER_A     = 1;
	localparam int SRC_PIN_B       = 2;
	localparam int SRC_CNT_ARRAY   = 3;
	localparam int SRC_SER_TIMER_B = 4;
	// Enable register bit positions
	localparam int GLOBAL_EN_BIT   = 7;
	localparam logic [7:0] ENABLE_USED_MASK = 8'h9f;
	localparam logic [7:0] ENABLE_RESET     = 8'h00;
	localparam logic [7:0] LEVEL_USED_MASK  = 8'h1f;
	localparam logic [7:0] LEVEL_RESET      = 8'h00;
	localparam logic [7:0] ZERO_BYTE        = 8'h00;
	// Register addresses
	localparam logic [3:0] ADDR_ENABLE = 4'h0;
	localparam logic [3:0] ADDR_LEVEL  = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_MASK   = 4'h3;
	localparam logic [3:0] ADDR_ACTIVE = 4'h4;
	localparam logic [3:0] ADDR_VEC    = 4'h5;
	// Program addresses
	localparam logic [11:0] RESET_VECTOR   = 12'h000;
	localparam logic [11:0] VEC_PIN_A      = 12'h003;
	localparam logic [11:0] VEC_TIMER_A    = 12'h00b;
	localparam logic [11:0] VEC_PIN_B      = 12'h013;
	localparam logic [11:0] VEC_CNT_ARRAY  = 12'h01b;
	localparam logic [11:0] VEC_SER_TIMERB = 12'h023;
	// Status bits of the event register
	localparam int EVT_ACCEPT   = 0;
	localparam int EVT_RETURN   = 1;
	localparam int EVT_NESTED   = 2;
	localparam logic [7:0] EVT_RESET = 8'h00;

	// Request presented to the core
	typedef struct packed {
		logic        valid;
		logic        level;
		logic [2:0]  src;
		logic [11:0] vector;
	} fpvi_req_s;

	// Service state of the controller
	typedef enum logic [1:0] {
		FPVI_IDLE   = 2'b00,
		FPVI_LOW    = 2'b01,
		FPVI_HIGH   = 2'b10,
		FPVI_NESTED = 2'b11
	} fpvi_state_e;
endpackage

// ---- fpvi_sync.sv ----
// Two-flop synchroniser bank for pin-level request inputs
module fpvi_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	// Hold when the clock enable is low
	always_comb
	begin
		meta_d = ce ? async_in : meta_q;
		sync_d = ce ? meta_q : sync_q;
	end

	// First stage feeds only the second
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule

// ---- fpvi_core.sv ----
// Fixed priority vectored interrupt controller, top level
// Summary of operation
// - After reset the fetch address presented to the core is zero.
// - Each accepted source vectors to its own fixed program address.
// - Simultaneous requests of one level resolve in fixed order, pin A highest.
// - Two priority levels; high-level requests win over low-level ones.
// - Serial and timer B flags share one request, enable and vector.
// - Enable register: bit 7 global, bits 4..0 per source.
//
// The placing of the registers and strobed register access were left to the implementer.
module fpvi_core (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	input  wire logic                  ext_pin_irq_a,
	input  wire logic                  ext_pin_irq_b,
	input  wire logic                  timer_a_overflow_flag,
	input  wire logic                  counter_array,
	input  wire logic                  serial_flag,
	input  wire logic                  timer_b_overflow_flag,
	input  wire logic                  core_ack,
	input  wire logic                  core_reti,
	input  wire logic [3:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	output fpvi_pkg::fpvi_req_s        core_req,
	output logic      [11:0]           fetch_addr,
	output logic                       irq_out
);
	// Pins come from outside the clock domain
	logic [1:0] pin_sync;

	fpvi_sync #(
		.W(2)
	) u_pin_sync (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.async_in ({ext_pin_irq_b, ext_pin_irq_a}),
		.sync_out (pin_sync)
	);

	// Registers
	logic [7:0]                 enable_q;
	logic [7:0]                 enable_d;
	logic [7:0]                 level_q;
	logic [7:0]                 level_d;
	logic [7:0]                 status_q;
	logic [7:0]                 status_d;
	logic [7:0]                 mask_q;
	logic [7:0]                 mask_d;
	logic [7:0]                 rdata_q;
	logic [7:0]                 rdata_d;
	fpvi_pkg::fpvi_state_e      state_q;
	fpvi_pkg::fpvi_state_e      state_d;
	fpvi_pkg::fpvi_req_s        req_q;
	fpvi_pkg::fpvi_req_s        req_d;
	logic [11:0]                fetch_q;
	logic [11:0]                fetch_d;
	logic [2:0]                 lo_src_q;
	logic [2:0]                 lo_src_d;
	logic                       irq_q;
	logic                       irq_d;

	// Combinational helpers
	logic [fpvi_pkg::SRC_N-1:0] raw_src;
	logic [fpvi_pkg::SRC_N-1:0] gated;
	logic [fpvi_pkg::SRC_N-1:0] gated_hi;
	logic [fpvi_pkg::SRC_N-1:0] gated_lo;
	logic [fpvi_pkg::SRC_N-1:0] pick_set;
	logic                       pick_valid;
	logic                       pick_level;
	logic [2:0]                 pick_src;
	logic [11:0]                pick_vec;
	logic                       may_hi;
	logic                       may_lo;
	logic [7:0]                 events;

	// Source vector; the shared line is an OR of serial and timer B
	always_comb
	begin
		raw_src = '0;
		raw_src[fpvi_pkg::SRC_PIN_A]       = pin_sync[0];
		raw_src[fpvi_pkg::SRC_TIMER_A]     = timer_a_overflow_flag;
		raw_src[fpvi_pkg::SRC_PIN_B]       = pin_sync[1];
		raw_src[fpvi_pkg::SRC_CNT_ARRAY]   = counter_array;
		raw_src[fpvi_pkg::SRC_SER_TIMER_B] = serial_flag
			| timer_b_overflow_flag;
	end

	// Gate each source with its own and the global enable
	always_comb
	begin
		gated = raw_src & enable_q[fpvi_pkg::SRC_N-1:0]
			& {fpvi_pkg::SRC_N{enable_q[fpvi_pkg::GLOBAL_EN_BIT]}};
		gated_hi = gated & level_q[fpvi_pkg::SRC_N-1:0];
		gated_lo = gated & ~level_q[fpvi_pkg::SRC_N-1:0];
	end

	// Which level may interrupt given what is in service
	always_comb
	begin
		may_hi = (state_q == fpvi_pkg::FPVI_IDLE)
			|| (state_q == fpvi_pkg::FPVI_LOW);
		may_lo = (state_q == fpvi_pkg::FPVI_IDLE);
	end

	// Pick level first, then fixed order within the level
	always_comb
	begin
		pick_valid = 1'b0;
		pick_level = 1'b0;
		pick_set   = '0;
		pick_src   = 3'(fpvi_pkg::SRC_N);
		if (may_hi && (gated_hi != '0))
		begin
			pick_set   = gated_hi;
			pick_level = 1'b1;
		end
		else if (may_lo)
		begin
			pick_set = gated_lo;
		end
		// lowest index wins, loop runs downward
		for (int i = fpvi_pkg::SRC_N - 1; i >= 0; i--)
		begin
			if (pick_set[i])
			begin
				pick_src   = 3'(i);
				pick_valid = 1'b1;
			end
		end
	end

	// Fixed vector table
	always_comb
	begin
		case (pick_src)
			3'(fpvi_pkg::SRC_PIN_A):       pick_vec = fpvi_pkg::VEC_PIN_A;
			3'(fpvi_pkg::SRC_TIMER_A):     pick_vec = fpvi_pkg::VEC_TIMER_A;
			3'(fpvi_pkg::SRC_PIN_B):       pick_vec = fpvi_pkg::VEC_PIN_B;
			3'(fpvi_pkg::SRC_CNT_ARRAY):   pick_vec = fpvi_pkg::VEC_CNT_ARRAY;
			3'(fpvi_pkg::SRC_SER_TIMER_B): pick_vec = fpvi_pkg::VEC_SER_TIMERB;
			default:                       pick_vec = fpvi_pkg::RESET_VECTOR;
		endcase
	end

	// Service state: accept on ack, unwind on return
	always_comb
	begin
		state_d  = state_q;
		lo_src_d = lo_src_q;
		fetch_d  = fetch_q;
		events   = '0;
		if (core_ack && req_q.valid)
		begin
			events[fpvi_pkg::EVT_ACCEPT] = 1'b1;
			fetch_d = req_q.vector;
			case (state_q)
				fpvi_pkg::FPVI_IDLE:
				begin
					state_d = req_q.level ? fpvi_pkg::FPVI_HIGH
						: fpvi_pkg::FPVI_LOW;
				end
				fpvi_pkg::FPVI_LOW:
				begin
					// A high request preempted a low handler
					state_d = fpvi_pkg::FPVI_NESTED;
					events[fpvi_pkg::EVT_NESTED] = 1'b1;
				end
				default:
				begin
					state_d = state_q;
				end
			endcase
		end
		else if (core_reti)
		begin
			events[fpvi_pkg::EVT_RETURN] = 1'b1;
			case (state_q)
				fpvi_pkg::FPVI_NESTED: state_d = fpvi_pkg::FPVI_LOW;
				fpvi_pkg::FPVI_LOW:    state_d = fpvi_pkg::FPVI_IDLE;
				fpvi_pkg::FPVI_HIGH:   state_d = fpvi_pkg::FPVI_IDLE;
				default:               state_d = fpvi_pkg::FPVI_IDLE;
			endcase
		end
		if (core_ack && req_q.valid)
		begin
			lo_src_d = req_q.level ? lo_src_q : req_q.src;
		end
	end

	// Request output is registered; withdrawn when acknowledged
	always_comb
	begin
		req_d.valid  = pick_valid && !(core_ack && req_q.valid);
		req_d.level  = pick_level;
		req_d.src    = pick_src;
		req_d.vector = pick_vec;
		irq_d = (status_q & mask_q) != '0;
	end

	// Register file; status is cleared by reading, but a new event wins
	always_comb
	begin
		enable_d = enable_q;
		level_d  = level_q;
		mask_d   = mask_q;
		status_d = status_q;
		rdata_d  = fpvi_pkg::ZERO_BYTE;
		if (reg_wr)
		begin
			case (reg_addr)
				fpvi_pkg::ADDR_ENABLE:
					enable_d = reg_wdata & fpvi_pkg::ENABLE_USED_MASK;
				fpvi_pkg::ADDR_LEVEL:
					level_d = reg_wdata & fpvi_pkg::LEVEL_USED_MASK;
				fpvi_pkg::ADDR_MASK:
					mask_d = reg_wdata;
				default:
					mask_d = mask_q;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				fpvi_pkg::ADDR_ENABLE: rdata_d = enable_q;
				fpvi_pkg::ADDR_LEVEL:  rdata_d = level_q;
				fpvi_pkg::ADDR_STATUS:
				begin
					rdata_d  = status_q;
					status_d = fpvi_pkg::ZERO_BYTE;
				end
				fpvi_pkg::ADDR_MASK:   rdata_d = mask_q;
				fpvi_pkg::ADDR_ACTIVE:
					rdata_d = {3'h0, lo_src_q, 2'(state_q)};
				fpvi_pkg::ADDR_VEC:    rdata_d = fetch_q[7:0];
				default:               rdata_d = fpvi_pkg::ZERO_BYTE;
			endcase
		end
		status_d = status_d | events;
	end

	// State registers; clock enable freezes all of it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			enable_q <= fpvi_pkg::ENABLE_RESET;
			level_q  <= fpvi_pkg::LEVEL_RESET;
			status_q <= fpvi_pkg::EVT_RESET;
			mask_q   <= fpvi_pkg::ZERO_BYTE;
			rdata_q  <= fpvi_pkg::ZERO_BYTE;
			state_q  <= fpvi_pkg::FPVI_IDLE;
			req_q    <= '0;
			fetch_q  <= fpvi_pkg::RESET_VECTOR;
			lo_src_q <= '0;
			irq_q    <= 1'b0;
		end
		else if (ce)
		begin
			enable_q <= enable_d;
			level_q  <= level_d;
			status_q <= status_d;
			mask_q   <= mask_d;
			rdata_q  <= rdata_d;
			state_q  <= state_d;
			req_q    <= req_d;
			fetch_q  <= fetch_d;
			lo_src_q <= lo_src_d;
			irq_q    <= irq_d;
		end
	end

	assign reg_rdata  = rdata_q;
	assign core_req   = req_q;
	assign fetch_addr = fetch_q;
	assign irq_out    = irq_q;
endmodule

// ---- fpvi_monitor.sv ----
// Port checker for the vectored interrupt block, bound to its top
module fpvi_monitor (
	input wire logic          clk,
	input wire logic          rst,
	input wire logic          ce,
	input wire logic [3:0]    reg_addr,
	input wire logic [7:0]    reg_wdata,
	input wire logic          reg_wr,
	input wire logic          reg_rd,
	input wire logic [7:0]    reg_rdata,
	input fpvi_pkg::fpvi_req_s core_req,
	input wire logic          core_ack,
	input wire logic [11:0]   fetch_addr
);
	localparam logic [11:0] VT [5] = '{fpvi_pkg::VEC_PIN_A,
		fpvi_pkg::VEC_TIMER_A, fpvi_pkg::VEC_PIN_B,
		fpvi_pkg::VEC_CNT_ARRAY, fpvi_pkg::VEC_SER_TIMERB};
	logic [7:0] en_q;
	logic [7:0] en_p;
	// Shadow of the enable register; the older copy matches request timing
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			en_q <= 8'h00;
			en_p <= 8'h00;
		end
		else
		begin
			en_p <= en_q;
			if (ce && reg_wr && reg_addr == fpvi_pkg::ADDR_ENABLE)
				en_q <= reg_wdata & fpvi_pkg::ENABLE_USED_MASK;
		end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	reset_fetch_a:
	assert property ($past(rst) |-> fetch_addr == fpvi_pkg::RESET_VECTOR)
		else $error("fetch address not zero after reset");
	vector_map_a:
	assert property (core_req.valid |-> core_req.vector == VT[core_req.src])
		else $error("request vector does not match its source");
	ack_fetch_a:
	assert property (ce && core_ack && core_req.valid |=>
		fetch_addr == $past(core_req.vector) && !core_req.valid)
		else $error("accepted vector not taken into fetch address");
	fetch_hold_a:
	assert property (!$past(core_ack) |-> $stable(fetch_addr))
		else $error("fetch address moved without an accept");
	global_gate_a:
	assert property (core_req.valid |-> en_p[fpvi_pkg::GLOBAL_EN_BIT])
		else $error("request shown with global enable off");
	source_gate_a:
	assert property (core_req.valid |-> en_p[core_req.src])
		else $error("request shown with its source enable off");
	enable_read_a:
	assert property ($past(reg_rd) && $past(reg_addr) == fpvi_pkg::ADDR_ENABLE |->
		reg_rdata == en_p)
		else $error("enable register read back wrong");
	rdata_idle_a:
	assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
endmodule

bind fpvi_core fpvi_monitor fpvi_monitor_inst (.clk, .rst, .ce, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_req, .core_ack,
	.fetch_addr);

// ---- fpvi_cpu_model.sv ----
// Behavioural processor core that takes vectored requests
module fpvi_cpu_model (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          slow,
	input  fpvi_pkg::fpvi_req_s core_req,
	output logic               core_ack,
	output logic               core_reti,
	output logic [11:0]        taken_vec,
	output logic [7:0]         taken_cnt
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] wait_q;
	logic [2:0] hold_q;
	logic [1:0] depth_q;
	// Ack after a prompt or slow wait, return after a fixed handler time;
	// a request shown while a handler runs preempts it and pauses its timer
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			{core_ack, core_reti, wait_q, hold_q, depth_q} <= '0;
			taken_vec <= 12'h000;
			taken_cnt <= 8'h00;
		end
		else
		begin
			core_ack <= 1'b0;
			core_reti <= 1'b0;
			if (core_ack)
			begin
				taken_vec <= core_req.vector;
				taken_cnt <= taken_cnt + 8'h01;
				hold_q <= 3'h6;
				wait_q <= 3'h0;
				depth_q <= depth_q + 2'h1;
			end
			else if (core_req.valid)
			begin
				wait_q <= wait_q + 3'h1;
				core_ack <= wait_q >= (slow ? 3'h4 : 3'h0);
			end
			else if (hold_q != 3'h0)
			begin
				// Outer handler resumes for a full span after a nested one
				hold_q <= (hold_q == 3'h1 && depth_q > 2'h1) ? 3'h6
					: hold_q - 3'h1;
				depth_q <= depth_q - {1'b0, hold_q == 3'h1};
				core_reti <= hold_q == 3'h1;
			end
		end
endmodule

// ---- test_fixed_priority_vector_irq.sv ----
// Self-checking bench for the vectored interrupt block
module test_fixed_priority_vector_irq;
	timeunit 1ns;
	timeprecision 100ps;
	logic                clk, rst, ce, slow, reg_wr, reg_rd, irq_out;
	logic                core_ack, core_reti;
	logic [5:0]          src;
	logic [3:0]          reg_addr;
	logic [7:0]          reg_wdata, reg_rdata, taken_cnt, d;
	logic [11:0]         fetch_addr, taken_vec;
	fpvi_pkg::fpvi_req_s core_req;
	int                  n_fail, samples_checked, cnt, i;
	logic [11:0]         vt [6] = '{12'h003, 12'h00b, 12'h013, 12'h01b,
		12'h023, 12'h023};
	fpvi_core fpvi_core_inst (.clk, .rst, .ce, .ext_pin_irq_a(src[0]),
		.timer_a_overflow_flag(src[1]), .ext_pin_irq_b(src[2]),
		.counter_array(src[3]), .serial_flag(src[4]),
		.timer_b_overflow_flag(src[5]), .core_ack, .core_reti, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_req, .fetch_addr,
		.irq_out);
	fpvi_cpu_model fpvi_cpu_model_inst (.clk, .rst, .slow, .core_req,
		.core_ack, .core_reti, .taken_vec, .taken_cnt);
	// Free-running 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [11:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("read data", 12'(e), 12'(reg_rdata));
	endtask
	task automatic put(input logic [5:0] v);
		@(posedge clk);
		src <= v;
	endtask
	// Bounded wait for the core to take the next request
	task automatic take(input logic [11:0] e);
		int k;
		cnt++;
		for (k = 0; k < 80 && taken_cnt !== 8'(cnt); k++)
			@(posedge clk) #1;
		chk("accept count", 12'(cnt), 12'(taken_cnt));
		chk("vector", e, taken_vec);
		chk("fetch address", e, fetch_addr);
	endtask
	task automatic idle(input logic [11:0] n, input string nm);
		repeat (n) @(posedge clk);
		#1 chk(nm, 12'h000, 12'(core_req.valid));
	endtask
	task automatic t_regs;
		chk("reset fetch", 12'h000, fetch_addr);
		rd(4'h0, 8'h00);
		wr(4'h0, 8'hff);
		rd(4'h0, 8'h9f);
		rd(4'hf, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_vectors;
		wr(4'h0, 8'h9f);
		for (i = 0; i < 6; i++)
		begin
			put(6'h01 << i);
			take(vt[i]);
			put(6'h00);
			repeat (10) @(posedge clk);
		end
		$display("test vectors done");
	endtask
	// All sources held back, then released together to a slow core
	task automatic t_priority;
		slow <= 1'b1;
		wr(4'h0, 8'h00);
		put(6'h1f);
		idle(5, "gated request");
		wr(4'h0, 8'h9f);
		for (i = 0; i < 5; i++)
		begin
			take(vt[i]);
			put(src & ~(6'h01 << i));
		end
		$display("test priority done");
	endtask
	task automatic t_level;
		wr(4'h1, 8'h10);
		wr(4'h0, 8'h00);
		put(6'h11);
		repeat (5) @(posedge clk);
		wr(4'h0, 8'h9f);
		take(12'h023);
		put(6'h01);
		take(12'h003);
		// High request preempts the running low handler
		put(6'h10);
		take(12'h023);
		rd(4'h4, 8'h03);
		put(6'h00);
		wr(4'h1, 8'h00);
		$display("test level done");
	endtask
	// Masked event stays quiet until unmasked, then a status read clears it
	task automatic t_gate_irq;
		wr(4'h3, 8'h00);
		wr(4'h0, 8'h1f);
		put(6'h02);
		idle(6, "global off");
		wr(4'h0, 8'h82);
		take(12'h00b);
		put(6'h00);
		repeat (3) @(posedge clk);
		#1 chk("irq masked", 12'h000, 12'(irq_out));
		wr(4'h3, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk("irq raised", 12'h001, 12'(irq_out));
		// Accept, return and nested events have all been seen by now
		rd(4'h2, 8'h07);
		repeat (2) @(posedge clk);
		#1 chk("irq cleared", 12'h000, 12'(irq_out));
		$display("test gate irq done");
	endtask
	task automatic summarize;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		{rst, ce, slow, reg_wr, reg_rd, src} = 11'h600;
		{reg_addr, reg_wdata} = 12'h000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_vectors();
		t_priority();
		t_level();
		t_gate_irq();
		summarize();
	end
	// The tests take under 300 cycles; the 60 us limit allows about 6,000
	initial
	begin
		#60us;
		n_fail++;
		summarize();
	end
endmodule
